/* File: oss_params.svh */
// Constants for the oscillator source selector: offsets, fields, counts.
// Functional notes
// R1: Every reset loads start source from straps.
// R2: Internal starts: low, high 1 MHz, 32 MHz.
// R3: External start combines with external mode field.
// R4: Three-bit mode picks one of six modes.
// R5: Clock modes take input; crystal modes drive.
// R6: Low-power crystal mode serves watch crystals.
// R7: Software switches source between external and internal.
// R8: Monitor falls back to internal on failure.
// R9: Startup timer holds crystal until stable.
// R10: Failure sets sticky flag readable by software.
`ifndef OSS_PARAMS_SVH
`define OSS_PARAMS_SVH
`define OSS_CLK_NS 50
`define OSS_FAIL_TIME_NS 100000
`define OSS_FAIL_CYC (`OSS_FAIL_TIME_NS / `OSS_CLK_NS)
`define OSS_OST_EDGES 1024
`define OSS_CFG_SETTLE 2'h2
`define OSS_RSEL_EXT 3'h0
`define OSS_RSEL_LF 3'h1
`define OSS_RSEL_HF1M 3'h2
`define OSS_RSEL_HF32M 3'h3
`define OSS_GAIN_LOW 2'h0
`define OSS_GAIN_MED 2'h1
`define OSS_GAIN_HIGH 2'h2
`define OSS_ADR_CTRL 8'h00
`define OSS_ADR_STAT 8'h04
`define OSS_ADR_IRQ 8'h08
`define OSS_ADR_MASK 8'h0C
`define OSS_CTRL_HF 2
`define OSS_STAT_OST 3
`define OSS_STAT_FAIL 4
`define OSS_IRQ_FAIL 0
`define OSS_IRQ_READY 1
`define OSS_REQ_RST 2'h2
`define OSS_HF_RST 1'h0
`define OSS_IRQ_RST 2'h0
`define OSS_MASK_RST 2'h0
`endif

/* File: oss_pkg.sv */
// Types shared by the oscillator source selector.
package oss_pkg;
    typedef enum logic [1:0] {
        OSS_SRC_EXT = 2'h0,
        OSS_SRC_LF = 2'h1,
        OSS_SRC_HF = 2'h2
    } oss_src_t;

    typedef enum logic [2:0] {
        OSS_EXT_CLOCK_LOW_POWER = 3'h0,
        OSS_EXT_CLOCK_MEDIUM_POWER = 3'h1,
        OSS_EXT_CLOCK_HIGH_POWER = 3'h2,
        OSS_LOW_POWER_CRYSTAL = 3'h3,
        OSS_MEDIUM_GAIN_CRYSTAL = 3'h4,
        OSS_HIGH_GAIN_CRYSTAL = 3'h5
    } oss_ext_mode_t;

    typedef enum logic [4:0] {
        OSS_ST_INIT = 5'b00001,
        OSS_ST_INT = 5'b00010,
        OSS_ST_OST = 5'b00100,
        OSS_ST_EXT = 5'b01000,
        OSS_ST_FAIL = 5'b10000
    } oss_state_t;

    typedef struct packed {
        oss_src_t src;
        logic hf_32m;
        logic xtal_drive;
        logic [1:0] xtal_gain;
        logic ext_in_en;
    } oss_clk_ctl_t;
endpackage

/* File: oss_clk_watch.sv */
// Edge counter and stall detector for the synchronised external clock.
module oss_clk_watch #(
    parameter int EDGES = 1024,
    parameter int TIMEOUT = 2000
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Monitored source, already synchronised.
    input wire logic restart_i,
    input wire logic level_i,
    // Results.
    output logic done_o,
    output logic stale_o
);
    localparam int EW = $clog2(EDGES + 1);
    localparam int TW = $clog2(TIMEOUT + 1);
    logic prev_q, prev_d, rise;
    logic [EW-1:0] edge_q, edge_d;
    logic [TW-1:0] idle_q, idle_d;

    // Sampling at 50 ns limits the watched source to well below 10 MHz.
    always_comb begin
        rise = level_i & ~prev_q;
        prev_d = level_i;
        edge_d = edge_q;
        idle_d = idle_q;
        if (restart_i) begin
            edge_d = '0;
            idle_d = '0;
        end else begin
            if (rise && !done_o) begin
                edge_d = edge_q + EW'(1);
            end
            if (rise) begin
                idle_d = '0;
            end else if (!stale_o) begin
                idle_d = idle_q + TW'(1);
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prev_q <= 1'b0;
            edge_q <= '0;
            idle_q <= '0;
        end else begin
            prev_q <= prev_d;
            edge_q <= edge_d;
            idle_q <= idle_d;
        end
    end

    assign done_o = (edge_q == EW'(EDGES));
    assign stale_o = (idle_q == TW'(TIMEOUT));
endmodule // oss_clk_watch

/* File: oss_osc_select.sv */
// Oscillator source selection, startup timing and fail-safe fallback.
`include "oss_params.svh"
module oss_osc_select (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave.
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Non-volatile configuration fields.
    input wire logic [2:0] reset_osc_select_i,
    input wire logic [2:0] external_osc_mode_i,
    // External clock pin or crystal amplifier output.
    input wire logic ext_clk_i,
    // Clock control and events.
    output oss_pkg::oss_clk_ctl_t clk_ctl_o,
    output logic failsafe_o,
    output logic irq_o
);
    import oss_pkg::*;

    logic [5:0] cfg_s1_q, cfg_s2_q;
    logic ext_s1_q, ext_s2_q;
    logic [1:0] cfg_cnt_q, cfg_cnt_d;
    oss_state_t st_q, st_d;
    oss_ext_mode_t mode_q, mode_d;
    oss_src_t src_q, src_d, req_q, req_d;
    logic hf_q, hf_d;
    logic [1:0] irq_q, irq_d, mask_q, mask_d, irq_set;
    logic ack_q, ack_d;
    logic [31:0] dat_q, dat_d;
    oss_clk_ctl_t ctl_q, ctl_d;
    logic restart, edges_done, stale, acc, wr_ctrl, xtal;

    // Straps and the pin are asynchronous; the first stage feeds only the
    // second.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_s1_q <= 6'h00;
            cfg_s2_q <= 6'h00;
            ext_s1_q <= 1'b0;
            ext_s2_q <= 1'b0;
        end else begin
            cfg_s1_q <= {reset_osc_select_i, external_osc_mode_i};
            cfg_s2_q <= cfg_s1_q;
            ext_s1_q <= ext_clk_i;
            ext_s2_q <= ext_s1_q;
        end
    end

    // R9: startup timer.
    oss_clk_watch #(
        .EDGES(`OSS_OST_EDGES),
        .TIMEOUT(`OSS_FAIL_CYC)
    ) u_watch (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .restart_i(restart),
        .level_i(ext_s2_q),
        .done_o(edges_done),
        .stale_o(stale)
    );

    always_comb begin
        acc = wb_cyc_i & wb_stb_i & ~ack_q;
        wr_ctrl = acc & wb_we_i & wb_sel_i[0]
            & (wb_adr_i == `OSS_ADR_CTRL);
        // R5: crystal or clock input.
        xtal = (mode_q == OSS_LOW_POWER_CRYSTAL)
            | (mode_q == OSS_MEDIUM_GAIN_CRYSTAL)
            | (mode_q == OSS_HIGH_GAIN_CRYSTAL);
        cfg_cnt_d = cfg_cnt_q;
        st_d = st_q;
        mode_d = mode_q;
        src_d = src_q;
        req_d = req_q;
        hf_d = hf_q;
        restart = 1'b0;
        irq_set = 2'h0;
        if (cfg_cnt_q != `OSS_CFG_SETTLE) begin
            cfg_cnt_d = cfg_cnt_q + 2'h1;
        end
        // R7: software source request.
        if (wr_ctrl) begin
            req_d = oss_src_t'(wb_dat_i[1:0]);
            hf_d = wb_dat_i[`OSS_CTRL_HF];
        end
        case (st_q)
            OSS_ST_INIT: begin
                // R1: straps taken after settling.
                if (cfg_cnt_q == `OSS_CFG_SETTLE) begin
                    // R4: mode field decode.
                    mode_d = oss_ext_mode_t'(cfg_s2_q[2:0]);
                    // R2: internal start choices.
                    hf_d = (cfg_s2_q[5:3] == `OSS_RSEL_HF32M);
                    // R3: external start uses mode.
                    if (cfg_s2_q[5:3] == `OSS_RSEL_EXT) begin
                        req_d = OSS_SRC_EXT;
                    end else if (cfg_s2_q[5:3] == `OSS_RSEL_LF) begin
                        req_d = OSS_SRC_LF;
                    end else begin
                        req_d = OSS_SRC_HF;
                    end
                    st_d = OSS_ST_INT;
                end
            end
            OSS_ST_INT: begin
                if (req_q == OSS_SRC_EXT) begin
                    restart = 1'b1;
                    if (xtal) begin
                        st_d = OSS_ST_OST;
                    end else begin
                        st_d = OSS_ST_EXT;
                        src_d = OSS_SRC_EXT;
                        irq_set[`OSS_IRQ_READY] = 1'b1;
                    end
                end else if (req_q == OSS_SRC_LF) begin
                    src_d = OSS_SRC_LF;
                end else begin
                    src_d = OSS_SRC_HF;
                end
            end
            OSS_ST_OST: begin
                if (req_q != OSS_SRC_EXT) begin
                    st_d = OSS_ST_INT;
                end else if (stale) begin
                    // R8: dead crystal falls back.
                    st_d = OSS_ST_FAIL;
                    src_d = OSS_SRC_HF;
                    irq_set[`OSS_IRQ_FAIL] = 1'b1;
                end else if (edges_done) begin
                    // R9: switch only when stable.
                    st_d = OSS_ST_EXT;
                    src_d = OSS_SRC_EXT;
                    irq_set[`OSS_IRQ_READY] = 1'b1;
                end
            end
            OSS_ST_EXT: begin
                // R8: failure beats software.
                if (stale) begin
                    st_d = OSS_ST_FAIL;
                    src_d = OSS_SRC_HF;
                    // R10: sticky failure flag.
                    irq_set[`OSS_IRQ_FAIL] = 1'b1;
                end else if (req_q != OSS_SRC_EXT) begin
                    st_d = OSS_ST_INT;
                end
            end
            OSS_ST_FAIL: begin
                // A retry needs a fresh write so a dead source is not
                // re-entered in a loop.
                src_d = OSS_SRC_HF;
                if (wr_ctrl) begin
                    st_d = OSS_ST_INT;
                end
            end
            default: begin
                st_d = OSS_ST_INIT;
            end
        endcase
    end

    always_comb begin
        ctl_d.src = src_d;
        ctl_d.hf_32m = hf_d;
        ctl_d.xtal_drive = xtal
            & ((st_d == OSS_ST_OST) | (st_d == OSS_ST_EXT));
        ctl_d.ext_in_en = ~xtal & (st_d == OSS_ST_EXT);
        // R6: watch crystal gets low gain.
        if (mode_q == OSS_LOW_POWER_CRYSTAL) begin
            ctl_d.xtal_gain = `OSS_GAIN_LOW;
        end else if (mode_q == OSS_MEDIUM_GAIN_CRYSTAL) begin
            ctl_d.xtal_gain = `OSS_GAIN_MED;
        end else begin
            ctl_d.xtal_gain = `OSS_GAIN_HIGH;
        end
    end

    // Register access; set of an event wins over the read that clears it.
    always_comb begin
        ack_d = acc;
        mask_d = mask_q;
        irq_d = irq_q | irq_set;
        dat_d = dat_q;
        if (acc && wb_we_i && wb_sel_i[0]) begin
            if (wb_adr_i == `OSS_ADR_MASK) begin
                mask_d = wb_dat_i[1:0];
            end
        end else if (acc && !wb_we_i) begin
            if (wb_adr_i == `OSS_ADR_CTRL) begin
                dat_d = {29'h0, hf_q, req_q};
            end else if (wb_adr_i == `OSS_ADR_STAT) begin
                dat_d = {24'h0, mode_q, (st_q == OSS_ST_FAIL),
                    edges_done, hf_q, src_q};
            end else if (wb_adr_i == `OSS_ADR_IRQ) begin
                dat_d = {30'h0, irq_q};
                irq_d = irq_set;
            end else if (wb_adr_i == `OSS_ADR_MASK) begin
                dat_d = {30'h0, mask_q};
            end else begin
                dat_d = 32'h0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_cnt_q <= 2'h0;
            st_q <= OSS_ST_INIT;
            mode_q <= OSS_EXT_CLOCK_LOW_POWER;
            src_q <= OSS_SRC_HF;
            req_q <= oss_src_t'(`OSS_REQ_RST);
            hf_q <= `OSS_HF_RST;
            irq_q <= `OSS_IRQ_RST;
            mask_q <= `OSS_MASK_RST;
            ack_q <= 1'b0;
            dat_q <= 32'h0;
            ctl_q <= '{src: OSS_SRC_HF, hf_32m: 1'b0, xtal_drive: 1'b0,
                xtal_gain: 2'h0, ext_in_en: 1'b0};
        end else begin
            cfg_cnt_q <= cfg_cnt_d;
            st_q <= st_d;
            mode_q <= mode_d;
            src_q <= src_d;
            req_q <= req_d;
            hf_q <= hf_d;
            irq_q <= irq_d;
            mask_q <= mask_d;
            ack_q <= ack_d;
            dat_q <= dat_d;
            ctl_q <= ctl_d;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;
    assign clk_ctl_o = ctl_q;
    assign failsafe_o = (st_q == OSS_ST_FAIL);
    assign irq_o = |(irq_q & mask_q);

    AST_STRAP_LF: assert property (@(posedge clk_i) disable iff (rst_i) // R1
        (st_q == OSS_ST_INIT && cfg_cnt_q == `OSS_CFG_SETTLE
            && cfg_s2_q[5:3] == `OSS_RSEL_LF)
        |=> ##1 (ctl_q.src == OSS_SRC_LF))
        else $error("Low internal start not applied.");

    AST_STRAP_HF32: assert property (@(posedge clk_i) disable iff (rst_i) // R2
        (st_q == OSS_ST_INIT && cfg_cnt_q == `OSS_CFG_SETTLE
            && cfg_s2_q[5:3] == `OSS_RSEL_HF32M)
        |=> ##1 (ctl_q.src == OSS_SRC_HF && ctl_q.hf_32m))
        else $error("High internal 32 MHz start not applied.");

    AST_MODE_TAKEN: assert property (@(posedge clk_i) disable iff (rst_i) // R4
        (st_q == OSS_ST_INIT && cfg_cnt_q == `OSS_CFG_SETTLE)
        |=> (mode_q == $past(cfg_s2_q[2:0])))
        else $error("External mode field not taken.");

    // A software change of request may be seen one cycle before the state
    // leaves the external path, so the request is checked one cycle back.
    AST_EXT_ACTIVE: assert property (@(posedge clk_i) disable iff (rst_i) // R3
        (st_q == OSS_ST_EXT)
        |-> (ctl_q.src == OSS_SRC_EXT && $past(req_q) == OSS_SRC_EXT))
        else $error("External state without external source.");

    AST_CLOCK_INPUT: assert property (@(posedge clk_i) // R5
        disable iff (rst_i) (st_q == OSS_ST_EXT && !xtal)
        |-> (ctl_q.ext_in_en && !ctl_q.xtal_drive))
        else $error("Clock mode drives crystal or lacks input.");

    AST_WATCH_GAIN: assert property (@(posedge clk_i) disable iff (rst_i) // R6
        (st_q == OSS_ST_OST && mode_q == OSS_LOW_POWER_CRYSTAL)
        |-> (ctl_q.xtal_drive && ctl_q.xtal_gain == `OSS_GAIN_LOW))
        else $error("Watch crystal not driven at low gain.");

    AST_SW_SWITCH: assert property (@(posedge clk_i) disable iff (rst_i) // R7
        (st_q == OSS_ST_EXT && !stale && wr_ctrl
            && wb_dat_i[1:0] == OSS_SRC_LF)
        |-> ##3 (ctl_q.src == OSS_SRC_LF))
        else $error("Software switch to low internal missed.");

    AST_FAILSAFE: assert property (@(posedge clk_i) disable iff (rst_i) // R8
        (st_q == OSS_ST_EXT && stale)
        |=> (failsafe_o && ctl_q.src == OSS_SRC_HF && !ctl_q.ext_in_en))
        else $error("Clock failure not handled.");

    AST_OST_HOLD: assert property (@(posedge clk_i) disable iff (rst_i) // R9
        (st_q == OSS_ST_OST && !edges_done) |=> (ctl_q.src != OSS_SRC_EXT))
        else $error("Crystal used before startup count.");

    AST_FAIL_FLAG: assert property (@(posedge clk_i) disable iff (rst_i) // R10
        (st_q == OSS_ST_EXT && stale) |=> irq_q[`OSS_IRQ_FAIL] [*2])
        else $error("Failure flag not sticky.");
endmodule // oss_osc_select

/* File: oss_ext_source.sv */
// Behavioural external clock or crystal feeding the source selector.
module oss_ext_source (
    // Clock.
    input wire logic clk_i,
    // Control: run or stop, half period in system cycles.
    input wire logic run_i,
    input wire logic [3:0] half_i,
    // Source output.
    output logic ext_clk_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] cnt_q = 4'h0;
    initial ext_clk_o = 1'b0;
    // A dead oscillator stands still, which is what the monitor must catch.
    always @(posedge clk_i) begin
        if (run_i) begin
            if (cnt_q >= half_i - 4'h1) begin
                cnt_q <= 4'h0;
                ext_clk_o <= ~ext_clk_o;
            end else begin
                cnt_q <= cnt_q + 4'h1;
            end
        end
    end
endmodule // oss_ext_source

/* File: test_oscillator_source_select.sv */
// Self-checking bench for the oscillator source selector.
`include "oss_params.svh"
module test_oscillator_source_select;
    import oss_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [3:0] sel = 4'h0;
    logic run = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic [31:0] rd;
    logic [2:0] rsel = 3'h1;
    logic [2:0] xmode = 3'h0;
    logic ack;
    logic ext_clk;
    logic fsafe;
    logic irq;
    oss_clk_ctl_t ctl;
    int num_errors = 0;
    int tests_run = 0;
    int n;
    logic [2:0] st_sel[3] = '{`OSS_RSEL_LF, `OSS_RSEL_HF1M, `OSS_RSEL_HF32M};
    logic [2:0] st_exp[3] = '{3'h2, 3'h4, 3'h5};
    logic [1:0] gain_exp[3] = '{`OSS_GAIN_LOW, `OSS_GAIN_MED, `OSS_GAIN_HIGH};

    always #25 clk = ~clk;

    oss_osc_select DUT (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .reset_osc_select_i(rsel), .external_osc_mode_i(xmode),
        .ext_clk_i(ext_clk), .clk_ctl_o(ctl), .failsafe_o(fsafe),
        .irq_o(irq));
    // Six system cycles a period keeps the source well below the sync limit.
    oss_ext_source src_model (.clk_i(clk), .run_i(run), .half_i(4'h3),
        .ext_clk_o(ext_clk));

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp,
                         input string what);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= 4'hF;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk);
            k++;
        end while (ack !== 1'b1 && k < 20);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        sel <= 4'h0;
        if (ack !== 1'b1) begin
            num_errors++;
            $display("MISMATCH t=%0t no bus answer", $time);
            give_verdict();
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
                          input string what);
        bus(1'b0, a, 32'h0);
        check(rd, exp, what);
    endtask

    // Straps are taken three edges after release, shown from the fourth.
    task automatic do_reset(input logic [2:0] r, input logic [2:0] m);
        @(posedge clk);
        rst <= 1'b1;
        rsel <= r;
        xmode <= m;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        repeat (5) @(posedge clk);
    endtask

    task automatic wait_src(input oss_src_t s, input int bound,
                            input string what);
        int k;
        k = 0;
        while (ctl.src !== s && k < bound) begin
            @(posedge clk);
            k++;
        end
        check({30'h0, ctl.src}, {30'h0, s}, what);
        if (ctl.src !== s) begin
            give_verdict();
        end
    endtask

    initial begin
        for (int i = 0; i < 3; i++) begin
            do_reset(st_sel[i], 3'h0);
            check({29'h0, ctl.src, ctl.hf_32m}, {29'h0, st_exp[i]},
                  "start");
        end
        rd_chk(`OSS_ADR_MASK, 32'h0, "mask reset");
        $display("test internal_start done");
        run <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            do_reset(`OSS_RSEL_EXT, 3'(i));
            wait_src(OSS_SRC_EXT, 50, "clock mode");
            check({30'h0, ctl.ext_in_en, ctl.xtal_drive}, 32'h2,
                  "clk in");
        end
        $display("test clock_modes done");
        for (int i = 0; i < 3; i++) begin
            do_reset(`OSS_RSEL_EXT, 3'(i + 3));
            repeat (200) @(posedge clk);
            check({31'h0, ctl.src == OSS_SRC_EXT}, 32'h0, "held off");
            check({29'h0, ctl.xtal_drive, ctl.xtal_gain},
                  {29'h0, 1'b1, gain_exp[i]}, "crystal drive");
            wait_src(OSS_SRC_EXT, 8000, "crystal ready");
            bus(1'b0, `OSS_ADR_IRQ, 32'h0);
            check(rd & 32'h2, 32'h2, "ext in use flag");
        end
        $display("test crystal_modes done");
        bus(1'b1, `OSS_ADR_MASK, 32'h1);
        rd_chk(`OSS_ADR_IRQ, 32'h0, "flags clear");
        run <= 1'b0;
        for (n = 0; n < 3000 && fsafe !== 1'b1; n++) @(posedge clk);
        check({31'h0, fsafe}, 32'h1, "failsafe");
        check({30'h0, ctl.src}, {30'h0, OSS_SRC_HF}, "fallback src");
        repeat (2) @(posedge clk);
        check({31'h0, irq}, 32'h1, "fail irq");
        rd_chk(`OSS_ADR_IRQ, 32'h1, "fail flag");
        rd_chk(`OSS_ADR_IRQ, 32'h0, "read clears");
        check({31'h0, irq}, 32'h0, "irq low");
        $display("test failsafe done");
        bus(1'b1, `OSS_ADR_CTRL, 32'h1);
        wait_src(OSS_SRC_LF, 10, "switch to low");
        check({31'h0, fsafe}, 32'h0, "failsafe left");
        run <= 1'b1;
        bus(1'b1, `OSS_ADR_CTRL, 32'h0);
        wait_src(OSS_SRC_EXT, 8000, "switch to ext");
        // Leaving a running external source for the low oscillator.
        bus(1'b1, `OSS_ADR_CTRL, 32'h1);
        wait_src(OSS_SRC_LF, 10, "ext to low");
        bus(1'b1, `OSS_ADR_CTRL, 32'h0);
        wait_src(OSS_SRC_EXT, 8000, "back to ext");
        bus(1'b1, `OSS_ADR_CTRL, 32'h6);
        wait_src(OSS_SRC_HF, 10, "switch to high");
        check({31'h0, ctl.hf_32m}, 32'h1, "high 32");
        rd_chk(`OSS_ADR_CTRL, 32'h6, "ctrl readback");
        // Mode 5, count done, 32 MHz high internal source active.
        rd_chk(`OSS_ADR_STAT, 32'hAE, "status");
        rd_chk(8'h10, 32'h0, "unmapped");
        $display("test software_switch done");
        give_verdict();
    end
endmodule // test_oscillator_source_select
